// File: rtl/facility_if.sv
// link between processor side requester and facility responder
`timescale 1ns/1ps
interface facility_if;
   logic req;
   logic wr;
   logic [63:0] addr;
   logic [31:0] wdata;
   logic ack;
   logic [31:0] rdata;
   logic hit;
   modport requester (output req, output wr, output addr, output wdata,
      input ack, input rdata, input hit);
   modport responder (input req, input wr, input addr, input wdata,
      output ack, output rdata, output hit);
endinterface : facility_if

// File: rtl/facility_pkg.sv
// shared constants for the facility access link
package facility_pkg;
   localparam int ADDR_W = 64;
   localparam int DATA_W = 32;
   localparam int REAL_W = 48;
   localparam int TOP_W = 32;
   localparam logic [31:0] TOP_ONES = 32'hFFFFFFFF;
   localparam int PAGE_BYTES = 4096;
   localparam int PAGE_SHIFT = 12;
   localparam int NUM_WORDS = 16;
   localparam int IDX_W = 4;
   // word index field sits above the byte lane bits
   localparam int IDX_LSB = 2;
   // facility window: page offset 0x000..0x03F of the architected page
   localparam logic [47:0] FAC_PAGE = 48'hFFFFF0000000;
   // words 0..7 implemented registers, 8..11 ram words, rest unimplemented
   localparam int REG_WORDS = 8;
   localparam int RAM_WORDS = 12;
   // implemented bit mask for register words (big endian bit 0 = msb)
   localparam logic [31:0] REG_IMPL_MASK = 32'hFFFF00FF;
   localparam logic [31:0] RESET_WORD = 32'h00000000;
   localparam logic [31:0] ZERO_WORD = 32'h00000000;
endpackage : facility_pkg

// File: rtl/facility_requester.sv
// processor end: issues one load or store at a time to the facility space
`timescale 1ns/1ps
module facility_requester
(
   input wire logic clock,
   input wire logic rst,
   facility_if.requester link,
   input wire logic cmd_valid,
   input wire logic cmd_write,
   input wire logic [31:0] cmd_offset,
   input wire logic [31:0] cmd_data,
   input wire logic [31:0] cmd_keep,
   output logic cmd_ready,
   output logic done,
   output logic [31:0] load_data
);
   typedef enum logic [1:0] {IDLE = 2'b01, WAIT = 2'b10} state_e;
   state_e state_q, state_d;
   logic req_q, req_d, wr_q, wr_d, done_q, done_d;
   logic [63:0] addr_q, addr_d;
   logic [31:0] wdata_q, wdata_d, load_q, load_d, keep_q, keep_d;

   //////////////////////////////////////////////////////////////////////////
   // next state
   always_comb
   begin
      state_d = state_q;
      req_d = 1'b0;
      wr_d = wr_q;
      addr_d = addr_q;
      wdata_d = wdata_q;
      keep_d = keep_q;
      load_d = load_q;
      done_d = 1'b0;
      case (state_q)
         IDLE:
         begin
            if (cmd_valid)
            begin
               state_d = WAIT;
               req_d = 1'b1;
               wr_d = cmd_write;
               // short offset widened with all-ones top
               addr_d = {facility_pkg::TOP_ONES, cmd_offset};
               wdata_d = cmd_data & cmd_keep;
               keep_d = cmd_keep;
            end
         end
         WAIT:
         begin
            if (link.ack)
            begin
               state_d = IDLE;
               done_d = 1'b1;
               if (!wr_q)
                  load_d = link.rdata & keep_q;
            end
         end
         default:
            state_d = IDLE;
      endcase
   end

   //////////////////////////////////////////////////////////////////////////
   // registers
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         state_q <= IDLE;
         req_q <= 1'b0;
         wr_q <= 1'b0;
         done_q <= 1'b0;
         addr_q <= 64'h0000000000000000;
         wdata_q <= facility_pkg::ZERO_WORD;
         keep_q <= facility_pkg::ZERO_WORD;
         load_q <= facility_pkg::ZERO_WORD;
      end
      else
      begin
         state_q <= state_d;
         req_q <= req_d;
         wr_q <= wr_d;
         done_q <= done_d;
         addr_q <= addr_d;
         wdata_q <= wdata_d;
         keep_q <= keep_d;
         load_q <= load_d;
      end
   end

   assign link.req = req_q;
   assign link.wr = wr_q;
   assign link.addr = addr_q;
   assign link.wdata = wdata_q;
   assign cmd_ready = state_q[0]; // idle is the low one-hot bit
   assign done = done_q;
   assign load_data = load_q;
endmodule : facility_requester

// File: rtl/facility_responder.sv
// facility end: decodes architected addresses and answers loads and stores
`timescale 1ns/1ps
//////////////////////////////////////////////////////////////////////////////
// Functional notes
// - reserved bits read zero or last written
// - requester writes zeros into reserved bits
// - unimplemented words drop writes, read zeros
// - requester masks reserved bits of loads
// - bit 0 is msb, msb byte first
// - all-ones prefix sign extends, keep 48 bits
// - facilities live in top four gigabytes
// - ram reserved bits return last written
// - pages are fixed 4096 bytes
//////////////////////////////////////////////////////////////////////////////
module facility_responder
(
   input wire logic clock,
   input wire logic rst,
   facility_if.responder link,
   output logic [31:0] page_num,
   output logic [31:0] ctrl_word
);
   typedef enum logic [1:0] {IDLE = 2'b01, RESP = 2'b10} state_e;
   // handshake group
   state_e state_q;
   state_e state_d;
   logic ack_q;
   logic ack_d;
   // answer group: last answer data, window flag, page number
   logic [31:0] rdata_q;
   logic [31:0] rdata_d;
   logic hit_q;
   logic hit_d;
   logic [31:0] page_q;
   logic [31:0] page_d;
   // implemented register words and ram backed words
   logic [31:0] regs_q [facility_pkg::REG_WORDS];
   logic [31:0] regs_d [facility_pkg::REG_WORDS];
   logic [31:0] ram_q [facility_pkg::RAM_WORDS - facility_pkg::REG_WORDS];
   logic [31:0] ram_d [facility_pkg::RAM_WORDS - facility_pkg::REG_WORDS];
   // decode results
   logic [47:0] real_addr;
   logic top_ok;
   logic page_ok;
   logic line_ok;
   logic in_fac;
   logic [facility_pkg::IDX_W-1:0] idx;
   logic is_reg;
   logic is_ram;
   logic take;
   logic store_reg;
   logic store_ram;

   //////////////////////////////////////////////////////////////////////////
   // address decode; only the low 48 bits exist below the top check
   always_comb
   begin
      real_addr = link.addr[facility_pkg::REAL_W-1:0];
      // upper half must be all ones: facilities sit in the top 4 GB
      top_ok = (link.addr[63:facility_pkg::ADDR_W-facility_pkg::TOP_W]
         == facility_pkg::TOP_ONES);
      // upper 36 bits of real address select the architected page
      page_ok = (real_addr[47:facility_pkg::PAGE_SHIFT]
         == facility_pkg::FAC_PAGE[47:facility_pkg::PAGE_SHIFT]);
      // only the first 64 bytes of the page are decoded
      line_ok = (real_addr[11:6] == 6'h00);
      in_fac = top_ok && page_ok && line_ok;
      idx = real_addr[facility_pkg::IDX_LSB +: facility_pkg::IDX_W];
      is_reg = in_fac && (idx < 4'(facility_pkg::REG_WORDS));
      // words 12..15 match neither test and stay unimplemented
      is_ram = in_fac && !is_reg && (idx < 4'(facility_pkg::RAM_WORDS));
   end

   //////////////////////////////////////////////////////////////////////////
   // request qualifiers; a request is taken only in the idle state
   always_comb
   begin
      take = link.req && (state_q == IDLE);
      store_reg = take && link.wr && is_reg;
      store_ram = take && link.wr && is_ram;
   end

   //////////////////////////////////////////////////////////////////////////
   // handshake next state; one request answered per two cycles, so a
   // request in the answer cycle is ignored
   always_comb
   begin
      state_d = state_q;
      ack_d = 1'b0;
      case (state_q)
         IDLE:
         begin
            if (link.req)
            begin
               state_d = RESP;
               ack_d = 1'b1;
            end
         end
         RESP:
         begin
            state_d = IDLE;
         end
         default:
         begin
            state_d = IDLE;
         end
      endcase
   end

   // handshake registers
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         state_q <= IDLE;
         ack_q <= 1'b0;
      end
      else
      begin
         state_q <= state_d;
         ack_q <= ack_d;
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // answer next values; read data holds until the next answer
   always_comb
   begin
      rdata_d = rdata_q;
      hit_d = hit_q;
      page_d = page_q;
      if (take)
      begin
         hit_d = in_fac;
         page_d = link.addr[facility_pkg::PAGE_SHIFT +: 32];
         // stores, misses and unimplemented words answer with zero
         rdata_d = facility_pkg::ZERO_WORD;
         if (!link.wr && is_reg)
         begin
            // word passed as-is: bit 0 is the msb, msb byte first
            rdata_d = regs_q[idx[2:0]];
         end
         else if (!link.wr && is_ram)
         begin
            rdata_d = ram_q[idx[1:0]];
         end
      end
   end

   // answer registers
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         rdata_q <= facility_pkg::RESET_WORD;
         hit_q <= 1'b0;
         page_q <= facility_pkg::RESET_WORD;
      end
      else
      begin
         rdata_q <= rdata_d;
         hit_q <= hit_d;
         page_q <= page_d;
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // register words keep implemented bits only, so reserved bits read zero
   always_comb
   begin
      regs_d = regs_q;
      if (store_reg)
      begin
         regs_d[idx[2:0]] = link.wdata & facility_pkg::REG_IMPL_MASK;
      end
   end

   // register word storage
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         for (int i = 0; i < facility_pkg::REG_WORDS; i++)
         begin
            regs_q[i] <= facility_pkg::RESET_WORD;
         end
      end
      else
      begin
         regs_q <= regs_d;
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // ram words keep every bit, reserved ones included; writes to
   // unimplemented words match neither store and are dropped
   always_comb
   begin
      ram_d = ram_q;
      if (store_ram)
      begin
         ram_d[idx[1:0]] = link.wdata;
      end
   end

   // ram word storage
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         for (int i = 0; i < facility_pkg::RAM_WORDS - facility_pkg::REG_WORDS; i++)
         begin
            ram_q[i] <= facility_pkg::RESET_WORD;
         end
      end
      else
      begin
         ram_q <= ram_d;
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // outputs straight from registers
   assign link.ack = ack_q;
   assign link.rdata = rdata_q;
   assign link.hit = hit_q;
   assign page_num = page_q;
   assign ctrl_word = regs_q[0];
endmodule : facility_responder

// File: testbench/facility_props.sv
// concurrent checks on the facility link
`timescale 1ns/1ps
module facility_props
(
   input wire logic clock,
   input wire logic rst,
   input wire logic req,
   input wire logic wr,
   input wire logic [63:0] addr,
   input wire logic [31:0] wdata,
   input wire logic ack,
   input wire logic [31:0] rdata,
   input wire logic hit
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);
   ////////////////////////////////////////////////////////////
   // window decode from the address alone, independent of the design
   logic in_win;
   logic rd;
   assign in_win = addr[63:32] == 32'hFFFFFFFF && addr[11:6] == 6'h00
      && addr[47:12] == facility_pkg::FAC_PAGE[47:12];
   assign rd = req && !wr;
   sequence s_answer;
      ##1 ack ##1 !ack;
   endsequence
   chk_req_answered: assert property (req |-> s_answer)
      else $error("request not answered by one ack");
   chk_req_spacing: assert property (req |=> !req)
      else $error("requests too close");
   chk_top_ones: assert property (req |-> addr[63:32] == 32'hFFFFFFFF)
      else $error("upper address bits not all ones");
   chk_hit_decode: assert property (req |=> hit == $past(in_win))
      else $error("hit disagrees with decode");
   chk_miss_zero: assert property (rd && !in_win |=> rdata == 32'h00000000)
      else $error("miss read not zero");
   chk_unimpl_zero: assert property (rd && in_win && addr[5:2] >= 4'hC |=> rdata == 32'h0)
      else $error("unimplemented word read not zero");
   chk_reg_reserved: assert property (rd && in_win && addr[5:2] < 4'h8 |=>
      (rdata & ~facility_pkg::REG_IMPL_MASK) == 32'h00000000)
      else $error("reserved register bits not zero");
   chk_rdata_held: assert property (!ack |-> $stable(rdata))
      else $error("read data moved without ack");
endmodule : facility_props

// File: testbench/testbench.sv
// self-checking bench joining both ends of the facility link
`timescale 1ns/1ps
module testbench;
   logic clock = 1'b0;
   logic rst = 1'b1;
   logic cmd_valid = 1'b0;
   logic cmd_write = 1'b0;
   logic [31:0] cmd_offset = 32'h0, cmd_data = 32'h0, cmd_keep = 32'h0;
   logic cmd_ready, done;
   logic [31:0] load_data, page_num, ctrl_word, d, last_load;
   logic [31:0] seed = 32'h2564C9D0;
   logic [31:0] mem [16];
   logic [31:0] exp_q [$];
   logic [31:0] miss_off [4] = '{32'hF0001000, 32'hE0000000, 32'hF0000040, 32'hF0000FC0};
   int err_total = 0;
   int check_count = 0;
   facility_if link ();
   facility_responder i_facility_responder (.clock(clock), .rst(rst), .link(link.responder),
      .page_num(page_num), .ctrl_word(ctrl_word));
   facility_requester i_facility_requester (.clock(clock), .rst(rst), .link(link.requester),
      .cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_offset(cmd_offset),
      .cmd_data(cmd_data), .cmd_keep(cmd_keep), .cmd_ready(cmd_ready), .done(done),
      .load_data(load_data));
   facility_props i_facility_props (.clock(clock), .rst(rst), .req(link.req), .wr(link.wr),
      .addr(link.addr), .wdata(link.wdata), .ack(link.ack), .rdata(link.rdata), .hit(link.hit));
   always #5 clock = ~clock;
   ////////////////////////////////////////////////////////////
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction : xs
   task automatic check(input logic [31:0] got, input logic [31:0] want);
      check_count++;
      if (got !== want)
      begin
         err_total++;
         $display("wrong value at %0t: got %h expected %h", $time, got, want);
      end
   endtask : check
   task automatic stop_test;
      $display("checks %0d mismatches %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : stop_test
   // bounded wait, so a stuck requester ends the run
   task automatic wait_ready;
      int n;
      n = 0;
      while (cmd_ready !== 1'b1 && n < 20)
      begin
         @(negedge clock);
         n++;
      end
      if (cmd_ready !== 1'b1)
      begin
         err_total++;
         stop_test();
      end
   endtask : wait_ready
   // note the expected result, then present the command for one take
   task automatic issue(input logic w, input logic [31:0] off, dat, keep);
      logic ok;
      ok = off[31:12] == 20'hF0000 && off[11:6] == 6'h00 && off[5:2] < 4'hC;
      wait_ready();
      if (w && ok)
         mem[off[5:2]] = dat & keep
            & (off[5] ? 32'hFFFFFFFF : facility_pkg::REG_IMPL_MASK);
      if (!w)
         last_load = ok ? (mem[off[5:2]] & keep) : 32'h0;
      exp_q.push_back(last_load);
      cmd_valid = 1'b1;
      cmd_write = w;
      cmd_offset = off;
      cmd_data = dat;
      cmd_keep = keep;
      @(negedge clock);
      cmd_valid = 1'b0;
   endtask : issue
   ////////////////////////////////////////////////////////////
   // monitor: each done retires the oldest note
   always @(negedge clock)
      if (done === 1'b1)
         check(load_data, exp_q.size() > 0 ? exp_q.pop_front() : ~load_data);
   initial
   begin
      last_load = 32'h0;
      foreach (mem[i]) mem[i] = 32'h0;
      repeat (10) @(negedge clock);
      rst = 1'b0;
      for (int i = 0; i < 16; i++)
         issue(1'b0, 32'hF0000000 + 32'(i * 4), 32'h0, 32'hFFFFFFFF);
      $display("test reset reads done");
      for (int i = 0; i < 300; i++)
      begin
         seed = xs(seed);
         d = xs(seed);
         issue(seed[7], {26'h3C00000, seed[5:2], 2'b00}, d, seed[6] ? 32'hFFFFFFFF : xs(d));
      end
      $display("test random traffic done");
      foreach (miss_off[i])
      begin
         issue(1'b1, miss_off[i], 32'hFFFFFFFF, 32'hFFFFFFFF);
         issue(1'b0, miss_off[i], 32'h0, 32'hFFFFFFFF);
         issue(1'b0, 32'hF0000000, 32'h0, 32'hFFFFFFFF);
      end
      wait_ready();
      repeat (3) @(negedge clock);
      check(page_num, 32'hFFFF0000);
      check(ctrl_word, mem[0]);
      check(32'(exp_q.size()), 32'h0);
      $display("test misses done");
      // mid-run reset: data outputs and done must clear, cmd_ready must be high, and both word stores must clear
      rst = 1'b1;
      repeat (3) @(negedge clock);
      rst = 1'b0;
      foreach (mem[i]) mem[i] = 32'h0;
      last_load = 32'h0;
      check(load_data, 32'h0);
      check(page_num, 32'h0);
      check(ctrl_word, 32'h0);
      check(32'(cmd_ready), 32'h1);
      check(32'(done), 32'h0);
      // first command straight after release; ram and register words read cleared
      issue(1'b0, 32'hF0000020, 32'h0, 32'hFFFFFFFF);
      issue(1'b0, 32'hF0000004, 32'h0, 32'hFFFFFFFF);
      wait_ready();
      repeat (2) @(negedge clock);
      check(32'(exp_q.size()), 32'h0);
      $display("test mid-run reset done");
      stop_test();
   end
endmodule : testbench
